// ---- mgf_top.sv ----
// Implementation choice: the APB slave port.
`default_nettype none
// transmit gap timing and receive-buffer flow control
// registers sit on pclk; gap sequencing and jamming run on link_clk
module mgf_top #(
  parameter int BLK_W = 16 // width of the receive block count
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [BLK_W-1:0] rx_blocks_remaining,
  output logic pause_req,
  output logic [15:0] rx_read_pointer,
  input wire logic link_clk,
  input wire logic crs,
  input wire logic tx_frame_end,
  input wire logic tx_next_ready,
  output logic tx_gap_open,
  output logic jam_tx_en,
  output logic [3:0] jam_txd
);
  // ---------------- register state (pclk) ----------------
  logic duplex_q;        // 1 = full duplex
  logic [6:0] b2b_q;     // back-to-back gap, bit 7 reads zero
  logic [6:0] extra_q;   // extra clocks for a non-adjacent gap
  logic [7:0] rrpl_q;    // read pointer low byte
  logic [4:0] rrph_q;    // read pointer bits 12:8
  logic [7:0] thr_q;     // flow-control threshold register
  logic [31:0] rdata_d;  // read mux
  logic hit_d;           // address maps to a register
  logic wr_en;           // write takes effect this edge

  // ---------------- flow control (pclk) ----------------
  logic [mgf_pkg::THR_W-1:0] thr_lvl; // live part of the threshold field
  logic below_d;         // blocks at or below a live threshold
  logic below_q;
  logic jam_q;           // level handed to the link domain

  // ---------------- gap config handshake ----------------
  logic [6:0] sh_b2b_q;   // shadow held stable while crossing
  logic [6:0] sh_extra_q;
  logic cfg_req_q;        // toggles once per new shadow
  logic cfg_ack_s;        // ack back in pclk domain
  logic gap_busy_s;       // link sequencer state in pclk domain
  logic cfg_pending;

  // ---------------- link domain ----------------
  logic link_rst_n;       // presetn, released on link_clk
  logic crs_s;            // carrier sense after two flops
  logic duplex_s;
  logic jam_s;
  logic cfg_req_s;
  logic cfg_ack_q;
  logic [6:0] lk_b2b_q;
  logic [6:0] lk_extra_q;
  logic lk_busy_q;
  mgf_pkg::mgf_link_state_t lk_state_q;
  logic lk_load_q;
  logic [7:0] lk_len_q;
  mgf_gap_if gap_if ();

  assign thr_lvl = thr_q[mgf_pkg::THR_W-1:0];
  assign wr_en = psel && penable && pready && pwrite;
  assign cfg_pending = (cfg_ack_s != cfg_req_q);

  // ---------------- APB slave ----------------
  // address decode and read mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    hit_d = 1'b1;
    case (paddr)
      mgf_pkg::ADDR_CFG: rdata_d = {31'h0, duplex_q};
      mgf_pkg::ADDR_B2B: rdata_d = {25'h0, b2b_q};
      mgf_pkg::ADDR_EXTRA: rdata_d = {25'h0, extra_q};
      mgf_pkg::ADDR_RRPL: rdata_d = {24'h00_0000, rrpl_q};
      mgf_pkg::ADDR_RRPH: rdata_d = {27'h0, rrph_q};
      mgf_pkg::ADDR_THR: rdata_d = {24'h00_0000, thr_q};
      mgf_pkg::ADDR_STAT: rdata_d = {28'h000_0000, gap_busy_s,
                                     cfg_pending, below_q, jam_q};
      default: hit_d = 1'b0; // unmapped: zero data and an error
    endcase
  end

  // answer in the first access cycle; data is latched at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= !hit_d;
      prdata <= pwrite ? 32'h0000_0000 : rdata_d;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duplex_q <= mgf_pkg::RST_DUPLEX;
      b2b_q <= mgf_pkg::RST_B2B;
      extra_q <= mgf_pkg::RST_EXTRA;
      thr_q <= mgf_pkg::RST_THR;
    end else if (wr_en) begin
      case (paddr)
        mgf_pkg::ADDR_CFG: duplex_q <= pwdata[mgf_pkg::CFG_DUPLEX_BIT];
        mgf_pkg::ADDR_B2B: b2b_q <= pwdata[6:0]; // bit 7 stays zero
        mgf_pkg::ADDR_EXTRA: extra_q <= pwdata[6:0];
        mgf_pkg::ADDR_THR: thr_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // receive read pointer; the top three bits are hard zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rrpl_q <= mgf_pkg::RST_RRPL;
      rrph_q <= mgf_pkg::RST_RRPH;
    end else if (wr_en && paddr == mgf_pkg::ADDR_RRPL) begin
      rrpl_q <= pwdata[7:0];
    end else if (wr_en && paddr == mgf_pkg::ADDR_RRPH) begin
      rrph_q <= pwdata[mgf_pkg::RRPH_W-1:0];
    end
  end

  // pointer output registered so it never glitches mid-write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_read_pointer <= 16'h0000;
    end else begin
      rx_read_pointer <= {3'b000, rrph_q, rrpl_q};
    end
  end

  // ---------------- flow control ----------------
  // a zero threshold switches the whole feature off
  assign below_d = (thr_lvl != '0) &&
                   (rx_blocks_remaining <= BLK_W'(thr_lvl));

  // remember the last comparison to find the crossing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      below_q <= 1'b0;
    end else begin
      below_q <= below_d;
    end
  end

  // full duplex: one pause request per crossing, never repeated
  // while the count stays low; software must free blocks first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_req <= 1'b0;
    end else begin
      pause_req <= below_d && !below_q && duplex_q;
    end
  end

  // half duplex: jam lasts while blocks stay at or below threshold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jam_q <= 1'b0;
    end else begin
      jam_q <= below_d && !duplex_q;
    end
  end

  // ---------------- gap config crossing ----------------
  // a new shadow is launched only when the last one was acknowledged,
  // so the link side always copies words that are standing still
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_b2b_q <= mgf_pkg::RST_B2B;
      sh_extra_q <= mgf_pkg::RST_EXTRA;
      cfg_req_q <= 1'b0;
    end else if (!cfg_pending &&
                 (sh_b2b_q != b2b_q || sh_extra_q != extra_q)) begin
      sh_b2b_q <= b2b_q;
      sh_extra_q <= extra_q;
      cfg_req_q <= !cfg_req_q;
    end
  end

  // link state and ack back into pclk
  mgf_sync #(.W(2)) u_sync_p (
    .clk(pclk),
    .rst_n(presetn),
    .d({cfg_ack_q, lk_busy_q}),
    .q({cfg_ack_s, gap_busy_s})
  );

  // ---------------- link clock domain ----------------
  // reset asserts at once and releases on a link edge
  mgf_sync #(.W(1)) u_sync_rst (
    .clk(link_clk),
    .rst_n(presetn),
    .d(1'b1),
    .q(link_rst_n)
  );

  // carrier pin and pclk levels into the link domain
  mgf_sync #(.W(4)) u_sync_l (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .d({crs, duplex_q, jam_q, cfg_req_q}),
    .q({crs_s, duplex_s, jam_s, cfg_req_s})
  );

  // copy the shadow once per request, then acknowledge
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lk_b2b_q <= mgf_pkg::RST_B2B;
      lk_extra_q <= mgf_pkg::RST_EXTRA;
      cfg_ack_q <= 1'b0;
    end else if (cfg_req_s != cfg_ack_q) begin
      lk_b2b_q <= sh_b2b_q;
      lk_extra_q <= sh_extra_q;
      cfg_ack_q <= cfg_req_s;
    end
  end

  // gap sequencer: back-to-back frames take the short gap, others
  // wait for a quiet medium first in half duplex
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lk_state_q <= mgf_pkg::LK_IDLE;
      lk_load_q <= 1'b0;
      lk_len_q <= 8'h00;
    end else begin
      lk_load_q <= 1'b0;
      case (lk_state_q)
        mgf_pkg::LK_IDLE: begin
          if (tx_frame_end && tx_next_ready) begin
            lk_state_q <= mgf_pkg::LK_GAP;
            lk_load_q <= 1'b1;
            // field plus the built-in delay
            lk_len_q <= {1'b0, lk_b2b_q} + mgf_pkg::GAP_B2B_INTRINSIC;
          end else if (tx_frame_end) begin
            lk_state_q <= mgf_pkg::LK_DEFER;
          end
        end
        mgf_pkg::LK_DEFER: begin
          // full duplex ignores carrier sense
          if (duplex_s || !crs_s) begin
            lk_state_q <= mgf_pkg::LK_GAP;
            lk_load_q <= 1'b1;
            // six clocks in all, two already spent in the flops
            lk_len_q <= {1'b0, lk_extra_q} + mgf_pkg::GAP_NONADJ_INTRINSIC
                        - mgf_pkg::CRS_SYNC_STAGES;
          end
        end
        mgf_pkg::LK_GAP: begin
          // the load pulse has not reached the timer yet on its cycle
          if (!lk_load_q && !gap_if.busy) begin
            lk_state_q <= mgf_pkg::LK_IDLE;
          end
        end
        default: lk_state_q <= mgf_pkg::LK_IDLE;
      endcase
    end
  end

  assign gap_if.load = lk_load_q;
  assign gap_if.len = lk_len_q;

  // counts the gap in link clocks
  mgf_gap_timer u_gap (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .gap(gap_if.timer)
  );

  // link outputs; jamming holds off any new frame
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_gap_open <= 1'b0;
      lk_busy_q <= 1'b0;
      jam_tx_en <= 1'b0;
      jam_txd <= 4'h0;
    end else begin
      tx_gap_open <= (lk_state_q == mgf_pkg::LK_IDLE) && !jam_s;
      lk_busy_q <= (lk_state_q != mgf_pkg::LK_IDLE);
      jam_tx_en <= jam_s && !duplex_s;
      jam_txd <= (jam_s && !duplex_s) ? mgf_pkg::JAM_NIBBLE : 4'h0;
    end
  end
endmodule // mgf_top
`default_nettype wire

// ---- mgf_pkg.sv ----
// Contract
// - nonadjacent gap: six clocks plus extra count
// - carrier sense synchronised through two flops
// - back-to-back gap field sets consecutive gap
// - gap register resets 15h, bit7 read-only
// - read pointer high byte, bits 7:5 zero
// - low six threshold bits start flow control
// - threshold zero disables flow control entirely
// - full duplex sends one pause frame
// - half duplex jams with 5h nibbles
// - jamming stops once blocks exceed threshold
// - duplex bit picks half or full duplex
`default_nettype none
package mgf_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_CFG = 10'h02a;   // duplex select
  localparam logic [9:0] IDX_B2B = 10'h02d;   // backtoback_gap
  localparam logic [9:0] IDX_EXTRA = 10'h02e; // nonadjacent_gap_extra
  localparam logic [9:0] IDX_RRPL = 10'h049;  // rx_read_pointer_low
  localparam logic [9:0] IDX_RRPH = 10'h04a;  // rx_read_pointer_high
  localparam logic [9:0] IDX_THR = 10'h04c;   // flow_control_threshold
  localparam logic [9:0] IDX_STAT = 10'h04d;  // read-only status
  localparam logic [11:0] ADDR_CFG = {IDX_CFG, 2'b00};
  localparam logic [11:0] ADDR_B2B = {IDX_B2B, 2'b00};
  localparam logic [11:0] ADDR_EXTRA = {IDX_EXTRA, 2'b00};
  localparam logic [11:0] ADDR_RRPL = {IDX_RRPL, 2'b00};
  localparam logic [11:0] ADDR_RRPH = {IDX_RRPH, 2'b00};
  localparam logic [11:0] ADDR_THR = {IDX_THR, 2'b00};
  localparam logic [11:0] ADDR_STAT = {IDX_STAT, 2'b00};
  // values after reset
  localparam logic [6:0] RST_B2B = 7'h15;
  localparam logic [6:0] RST_EXTRA = 7'h12;
  localparam logic [7:0] RST_RRPL = 8'h00;
  localparam logic [4:0] RST_RRPH = 5'h00;
  localparam logic [7:0] RST_THR = 8'h00;
  localparam logic RST_DUPLEX = 1'b0;
  // field positions
  localparam int CFG_DUPLEX_BIT = 0;
  localparam int THR_W = 6;
  localparam int RRPH_W = 5;
  // gap timing in link clocks, and the jam nibble
  localparam logic [7:0] GAP_B2B_INTRINSIC = 8'h03;
  localparam logic [7:0] GAP_NONADJ_INTRINSIC = 8'h06;
  localparam logic [7:0] CRS_SYNC_STAGES = 8'h02;
  localparam logic [3:0] JAM_NIBBLE = 4'h5;
  // link-side gap sequencer
  typedef enum logic [1:0] {LK_IDLE, LK_DEFER, LK_GAP} mgf_link_state_t;
endpackage : mgf_pkg
`default_nettype wire

// ---- mgf_gap_if.sv ----
`default_nettype none
// carries the gap timer's load request and its running state
interface mgf_gap_if;
  logic load;      // one-cycle pulse, starts a gap
  logic [7:0] len; // gap length in link clocks
  logic busy;      // gap still counting
  modport ctrl (output load, output len, input busy);
  modport timer (input load, input len, output busy);
endinterface : mgf_gap_if
`default_nettype wire

// ---- mgf_sync.sv ----
`default_nettype none
// plain two-flop synchroniser; the first stage feeds only the second
module mgf_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q; // may go metastable, read by q only

  // two stages give a full cycle for metastability to settle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // mgf_sync
`default_nettype wire

// ---- mgf_gap_timer.sv ----
`default_nettype none
// loadable down counter that times one transmit gap on the link clock
module mgf_gap_timer (
  input wire logic clk,
  input wire logic rst_n,
  mgf_gap_if.timer gap
);
  logic [7:0] cnt_q; // clocks still to wait

  // a load restarts the gap; otherwise count down to zero and stop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
    end else if (gap.load) begin
      cnt_q <= gap.len;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end

  assign gap.busy = (cnt_q != 8'h00);
endmodule // mgf_gap_timer
`default_nettype wire

// ---- mgf_phy_model.sv ----
`default_nettype none
// phy stand-in: link clock, carrier echo of own frames, jam watch
module mgf_phy_model (
  output logic link_clk,
  input wire logic tx_active,
  input wire logic [3:0] crs_lag,
  output logic crs,
  input wire logic jam_tx_en,
  input wire logic [3:0] jam_txd,
  output logic jam_bad
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] lag_q; // carrier hold-off countdown
  // mii-style clock runs free, phase unrelated to pclk
  initial begin
    link_clk = 1'b0;
    crs = 1'b0;
    lag_q = 4'h0;
    jam_bad = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end
  // carrier drops late so the sync path is exercised
  always @(posedge link_clk) begin
    if (tx_active) begin
      crs <= 1'b1;
      lag_q <= crs_lag;
    end else if (lag_q != 4'h0) begin
      lag_q <= lag_q - 4'h1;
    end else begin
      crs <= 1'b0;
    end
  end
  // any jam nibble other than 5h is flagged
  always @(posedge link_clk) begin
    if (jam_tx_en && jam_txd !== 4'h5) begin
      jam_bad <= 1'b1;
    end
  end
endmodule // mgf_phy_model
`default_nettype wire

// ---- mgf_top_chk.sv ----
`default_nettype none
// port checker: apb answers on pclk, gap and jam on link_clk
module mgf_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pause_req,
  input wire logic [15:0] rx_read_pointer,
  input wire logic link_clk,
  input wire logic tx_frame_end,
  input wire logic tx_gap_open,
  input wire logic jam_tx_en,
  input wire logic [3:0] jam_txd
);
  ready_on_access_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("no ready in access cycle");
  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");
  err_zero_data_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or zero data");
  ptr_top_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_read_pointer[15:13] == 3'h0)
    else $error("pointer top bits not zero");
  pause_single_a: assert property (@(posedge pclk) disable iff (!presetn)
    pause_req |=> !pause_req)
    else $error("pause request repeated");
  jam_pattern_a: assert property (@(posedge link_clk) disable iff (!presetn)
    jam_tx_en |-> jam_txd == 4'h5)
    else $error("jam nibble wrong");
  jam_quiet_a: assert property (@(posedge link_clk) disable iff (!presetn)
    !jam_tx_en |-> jam_txd == 4'h0)
    else $error("data while not jamming");
  jam_no_gap_a: assert property (@(posedge link_clk) disable iff (!presetn)
    jam_tx_en [*2] |-> !tx_gap_open)
    else $error("gap open while jamming");
  gap_close_a: assert property (@(posedge link_clk) disable iff (!presetn)
    tx_frame_end && tx_gap_open |-> ##[1:2] !tx_gap_open)
    else $error("gap did not start");
endmodule // mgf_top_chk
bind mgf_top mgf_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pause_req(pause_req), .rx_read_pointer(rx_read_pointer), .link_clk(link_clk),
  .tx_frame_end(tx_frame_end), .tx_gap_open(tx_gap_open), .jam_tx_en(jam_tx_en),
  .jam_txd(jam_txd));
`default_nettype wire

// ---- tb_mgf_top.sv ----
`default_nettype none
// bench: registers, gap lengths, pause and jam flow control
module tb_mgf_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] blk, rrp;
  logic link_clk, crs, fend, nxt, gopen, jam, jbad, pause, act;
  logic [3:0] jtxd, lag;
  int num_errors = 0;
  int total_checks = 0;
  int npause = 0; // pause pulses seen
  int n0, n1, n2, n3;
  // 100 mhz register clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  mgf_top #(.BLK_W(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_blocks_remaining(blk),
    .pause_req(pause), .rx_read_pointer(rrp), .link_clk(link_clk), .crs(crs),
    .tx_frame_end(fend), .tx_next_ready(nxt), .tx_gap_open(gopen),
    .jam_tx_en(jam), .jam_txd(jtxd));
  mgf_phy_model phy (.link_clk(link_clk), .tx_active(act), .crs_lag(lag), .crs(crs),
    .jam_tx_en(jam), .jam_txd(jtxd), .jam_bad(jbad));
  // pulse is one cycle wide, so one count per pulse
  always @(posedge pclk) begin
    if (pause === 1'b1) begin
      npause <= npause + 1;
    end
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // a limit that runs out ends the run as a failure
  task automatic hang();
    num_errors++;
    print_verdict();
  endtask
  // apb transfer: setup, then access held until pready is sampled
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) hang();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (20) @(posedge pclk); // config crosses to the link side
  endtask
  // link-side wait with a bound
  // on_jam picks the watched output: 0 = gap open, 1 = jam enable
  task automatic await(input bit on_jam, input logic v, output int n);
    n = 0;
    while ((on_jam ? jam : gopen) !== v && n < 600) begin
      @(posedge link_clk);
      n++;
    end
    if ((on_jam ? jam : gopen) !== v) hang();
  endtask
  // one frame with carrier, then link clocks until the gap reopens
  task automatic gap(input logic adj, output int n);
    await(1'b0, 1'b1, n);
    @(posedge link_clk);
    act <= 1'b1;
    repeat (4) @(posedge link_clk);
    act <= 1'b0;
    fend <= 1'b1;
    nxt <= adj;
    @(posedge link_clk);
    fend <= 1'b0;
    await(1'b0, 1'b0, n);
    await(1'b0, 1'b1, n);
  endtask
  task automatic setblk(input logic [15:0] v);
    @(posedge pclk);
    blk <= v;
    repeat (8) @(posedge pclk);
  endtask
  task automatic t_regs();
    apb(1'b0, mgf_pkg::ADDR_B2B, 32'h0);
    chk(rd, 32'h15);
    apb(1'b0, mgf_pkg::ADDR_THR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, mgf_pkg::ADDR_B2B, 32'hff);
    apb(1'b0, mgf_pkg::ADDR_B2B, 32'h0);
    chk(rd, 32'h7f);
    apb(1'b1, mgf_pkg::ADDR_RRPL, 32'h34);
    apb(1'b1, mgf_pkg::ADDR_RRPH, 32'hff);
    apb(1'b0, mgf_pkg::ADDR_RRPH, 32'h0);
    chk(rd, 32'h1f);
    chk({16'h0, rrp}, 32'h1f34);
    apb(1'b0, 12'hffc, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("regs done");
  endtask
  // gap differences cancel the fixed pipeline delay
  task automatic t_gap();
    gap(1'b1, n1);
    apb(1'b1, mgf_pkg::ADDR_B2B, 32'h05);
    gap(1'b1, n2);
    // the gap field still holds 7fh from the register test
    chk(32'(n1 - n2), 32'h7f - 32'h05);
    gap(1'b0, n1);
    apb(1'b1, mgf_pkg::ADDR_EXTRA, 32'h02);
    gap(1'b0, n2);
    chk(32'(n1 - n2), 32'd16);
    lag <= 4'd6;
    gap(1'b0, n3);
    chk(32'(n3 - n2), 32'd4);
    $display("gap done");
  endtask
  task automatic t_pause();
    n0 = npause;
    apb(1'b1, mgf_pkg::ADDR_CFG, 32'h1);
    apb(1'b1, mgf_pkg::ADDR_THR, 32'hc5);
    setblk(16'd5);
    chk(32'(npause - n0), 32'd1);
    setblk(16'd3);
    chk(32'(npause - n0), 32'd1);
    setblk(16'd6);
    setblk(16'd5);
    chk(32'(npause - n0), 32'd2);
    chk({31'h0, jam}, 32'h0);
    $display("pause done");
  endtask
  task automatic t_jam();
    setblk(16'd20);
    n0 = npause;
    apb(1'b1, mgf_pkg::ADDR_CFG, 32'h0);
    setblk(16'd5);
    await(1'b1, 1'b1, n1);
    chk({28'h0, jtxd}, 32'h5);
    chk(32'(npause - n0), 32'd0);
    setblk(16'd6);
    await(1'b1, 1'b0, n1);
    chk({31'h0, jam}, 32'h0);
    $display("jam done");
  endtask
  task automatic t_off();
    n0 = npause;
    apb(1'b1, mgf_pkg::ADDR_THR, 32'hc0);
    setblk(16'd0);
    repeat (40) @(posedge link_clk);
    chk({31'h0, jam}, 32'h0);
    chk(32'(npause - n0), 32'd0);
    chk({31'h0, jbad}, 32'h0);
    $display("off done");
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    blk = 16'd20;
    fend = 1'b0;
    nxt = 1'b0;
    act = 1'b0;
    lag = 4'd2;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
    t_regs();
    t_gap();
    t_pause();
    t_jam();
    t_off();
    print_verdict();
  end
endmodule // tb_mgf_top
`default_nettype wire
